// >>> src/dor_alu.sv
`timescale 1ns/1ps
`default_nettype none
module dor_alu (
  input  wire logic [31:0]           a,
  input  wire logic [31:0]           b,
  input  wire dor_pkg::dor_op_e      op,
  output logic      [31:0]           y
);
  logic [63:0] prod;

  // one operation per command, longer math takes several commands
  always_comb begin
    prod = a * b;
    case (op)
      dor_pkg::OP_MOV: y = b;
      dor_pkg::OP_ADD: y = a + b;
      dor_pkg::OP_SUB: y = a - b;
      dor_pkg::OP_MUL: y = prod[31:0];
      dor_pkg::OP_AND: y = a & b;
      dor_pkg::OP_OR:  y = a | b;
      default:         y = b;
    endcase
  end
endmodule
`default_nettype wire

// >>> src/dor_pkg.sv
// How it works
// RULE_01: each of the four outputs takes one function from its config field.
// RULE_02: a general-purpose output changes only by set commands, per output
// RULE_03: a fault output is active on a software, limit or stop fault.
// RULE_04: the program should raise a general output once as a drive-ok flag.
// RULE_05: a sequence-active output follows the running program sequence.
// RULE_06: a moving output is active from motion start until the motor stops.
// RULE_07: a slew output is active at target velocity until deceleration.
// RULE_08: the debounce time is 0 to 255 and is written by bus or sequencer.
// RULE_09: the feedback counter is a full signed 32-bit value, loadable.
// RULE_10: the position register can be loaded by a sequencer command.
// RULE_11: no index homing, stall detect or position hold exist in hardware.
// RULE_12: the sequencer executes one arithmetic operation per command.
// RULE_13: writes to read-only operands by a sequencer command are ignored.
// RULE_14: the acceleration operand reads back the last rate and is writable.
// RULE_15: the analog operand is read-only, 0 to 255, sampled on execution.
// RULE_16: outputs are flops recomputed every cycle from current status.
package dor_pkg;
  localparam int          NUM_OUT = 4;
  localparam int          FN_W    = 3;
  localparam logic [2:0]  FN_GP    = 3'h0;
  localparam logic [2:0]  FN_FAULT = 3'h1;
  localparam logic [2:0]  FN_SEQ   = 3'h2;
  localparam logic [2:0]  FN_MOVE  = 3'h3;
  localparam logic [2:0]  FN_SLEW  = 3'h4;
  // per-output set codes, two bits each
  localparam logic [1:0]  SET_KEEP = 2'h0;
  localparam logic [1:0]  SET_OFF  = 2'h1;
  localparam logic [1:0]  SET_ON   = 2'h2;
  // register byte offsets
  localparam logic [7:0]  A_OUT_CFG  = 8'h00;
  localparam logic [7:0]  A_OUT_SET  = 8'h04;
  localparam logic [7:0]  A_OUT_STAT = 8'h08;
  localparam logic [7:0]  A_DEBOUNCE = 8'h0C;
  localparam logic [7:0]  A_FEEDBACK = 8'h10;
  localparam logic [7:0]  A_POSITION = 8'h14;
  localparam logic [7:0]  A_ACCEL    = 8'h18;
  localparam logic [7:0]  A_ANALOG   = 8'h1C;
  localparam logic [7:0]  A_FAULT    = 8'h20;
  localparam logic [7:0]  A_STATUS   = 8'h24;
  localparam logic [7:0]  A_IRQ_STAT = 8'h28;
  localparam logic [7:0]  A_IRQ_CLR  = 8'h2C;
  localparam logic [7:0]  A_IRQ_EN   = 8'h30;
  // fault register bits
  localparam int          FLT_W    = 6;
  localparam int          FLT_SW   = 4;
  localparam int          FLT_STOP = 5;
  // status register bits
  localparam int          ST_W     = 6;
  localparam int          ST_SLEW  = 0;
  localparam int          ST_MOVE  = 1;
  localparam int          ST_DELAY = 2;
  localparam int          ST_STOP  = 3;
  localparam int          ST_DIS   = 4;
  localparam int          ST_SEQ   = 5;
  // interrupt event bits
  localparam int          IRQ_W          = 4;
  localparam int          IRQ_FAULT      = 0;
  localparam int          IRQ_SEQ_DONE   = 1;
  localparam int          IRQ_MOVE_START = 2;
  localparam int          IRQ_MOVE_DONE  = 3;
  // sequencer operands and operations
  localparam logic [3:0]  OPD_ACCEL    = 4'h0;
  localparam logic [3:0]  OPD_ANALOG   = 4'h1;
  localparam logic [3:0]  OPD_FAULT    = 4'h2;
  localparam logic [3:0]  OPD_FEEDBACK = 4'h3;
  localparam logic [3:0]  OPD_OUTSTATE = 4'h4;
  localparam logic [3:0]  OPD_POSITION = 4'h5;
  localparam logic [3:0]  OPD_STATUS   = 4'h6;
  localparam logic [3:0]  OPD_DEBOUNCE = 4'h7;
  typedef enum logic [2:0] {
    OP_MOV, OP_ADD, OP_SUB, OP_MUL, OP_AND, OP_OR, OP_OUTSET
  } dor_op_e;
  // reset values
  localparam logic [7:0]  DEB_RST   = 8'h00;
  localparam logic [7:0]  DEB_MAX   = 8'hFF;
  localparam logic [31:0] ACCEL_RST = 32'h0000_0000;
  // rate written to accel is in ministeps/s^2 at this many per revolution
  localparam int          ACCEL_MSTEP_PER_REV = 83886;
  // debounce unit is one millisecond
  localparam int          CLK_NS      = 40;
  localparam int          DEB_UNIT_NS = 1000000;
  localparam int          DEB_UNIT_CYC = DEB_UNIT_NS / CLK_NS;
endpackage

// >>> src/dor_sync.sv
`timescale 1ns/1ps
`default_nettype none
module dor_sync (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic d,
  output var  logic q
);
  logic s1;
  logic s2;
  logic s3;

  // q moves only once the two later stages agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      q  <= 1'b0;
    end else begin
      s1 <= d;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        q <= s3;
      end
    end
  end
endmodule
`default_nettype wire

// >>> src/dor_top.sv
// The APB register port and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
module dor_top #(
  parameter int DEB_UNIT_CYC = dor_pkg::DEB_UNIT_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq,
  input  wire logic        seq_active,
  input  wire logic        motor_moving,
  input  wire logic        vel_at_target,
  input  wire logic        decelerating,
  input  wire logic        in_delay,
  input  wire logic        drv_disabled,
  input  wire logic        sw_fault,
  input  wire logic [3:0]  hw_fault,
  input  wire logic        pos_step,
  input  wire logic        pos_dir,
  input  wire logic [7:0]  analog_in,
  input  wire logic        stop_pin,
  input  wire logic        enc_step_pin,
  input  wire logic        enc_dir_pin,
  input  wire logic        seq_cmd_valid,
  input  wire logic [2:0]  seq_cmd_op,
  input  wire logic [3:0]  seq_dst,
  input  wire logic [3:0]  seq_src_a,
  input  wire logic [3:0]  seq_src_b,
  input  wire logic        seq_use_imm,
  input  wire logic [31:0] seq_imm,
  output var  logic [31:0] seq_result,
  output var  logic        seq_result_valid,
  output var  logic        stop_clean,
  output var  logic [3:0]  out_pin
);
  localparam int NO = dor_pkg::NUM_OUT;
  localparam int FW = dor_pkg::FN_W;

  logic [NO*FW-1:0]         out_cfg;
  logic [NO-1:0]            out_gp;
  logic [7:0]               deb_time;
  logic [31:0]              feedback;
  logic [31:0]              position;
  logic [31:0]              accel;
  logic [dor_pkg::FLT_W-1:0] fault_reg;
  logic [dor_pkg::ST_W-1:0] status_reg;
  logic [dor_pkg::IRQ_W-1:0] irq_stat;
  logic [dor_pkg::IRQ_W-1:0] irq_en;
  logic [dor_pkg::IRQ_W-1:0] irq_evt;
  logic [2:0]               pin_raw;
  logic [2:0]               pin_q;
  logic                     stop_sync;
  logic                     enc_step_s;
  logic                     enc_dir_s;
  logic                     enc_step_d;
  logic                     enc_edge;
  logic [31:0]              tick_cnt;
  logic                     deb_tick;
  logic [7:0]               deb_cnt;
  logic                     fault_d;
  logic                     seq_d;
  logic                     move_d;
  logic                     setup;
  logic                     wr;
  logic [31:0]              op_a;
  logic [31:0]              op_b;
  logic [31:0]              alu_y;
  dor_pkg::dor_op_e         seq_op;
  logic                     seq_wr;
  logic                     seq_set;
  logic                     apb_set;
  logic                     set_any;
  logic                     fb_wr_any;
  logic [31:0]              apb_rd;

  // set command, per output: apply two-bit codes to the gp levels
  function automatic logic [NO-1:0] apply_set(input logic [NO-1:0] cur,
                                              input logic [2*NO-1:0] code);
    logic [NO-1:0] r;
    r = cur;
    for (int i = 0; i < NO; i++) begin
      if (code[2*i +: 2] == dor_pkg::SET_ON) begin
        r[i] = 1'b1;
      end else if (code[2*i +: 2] == dor_pkg::SET_OFF) begin
        r[i] = 1'b0;
      end
    end
    return r;
  endfunction

  function automatic logic [31:0] opd_val(input logic [3:0] sel);
    case (sel)
      dor_pkg::OPD_ACCEL:    opd_val = accel;
      dor_pkg::OPD_ANALOG:   opd_val = {24'h00_0000, analog_in};
      dor_pkg::OPD_FAULT:    opd_val = {26'h000_0000, fault_reg};
      dor_pkg::OPD_FEEDBACK: opd_val = feedback;
      dor_pkg::OPD_OUTSTATE: opd_val = {28'h000_0000, out_pin};
      dor_pkg::OPD_POSITION: opd_val = position;
      dor_pkg::OPD_STATUS:   opd_val = {26'h000_0000, status_reg};
      dor_pkg::OPD_DEBOUNCE: opd_val = {24'h00_0000, deb_time};
      default:               opd_val = 32'h0000_0000;
    endcase
  endfunction

  function automatic logic is_mapped(input logic [7:0] a);
    case (a)
      dor_pkg::A_OUT_CFG, dor_pkg::A_OUT_SET, dor_pkg::A_OUT_STAT,
      dor_pkg::A_DEBOUNCE, dor_pkg::A_FEEDBACK, dor_pkg::A_POSITION,
      dor_pkg::A_ACCEL, dor_pkg::A_ANALOG, dor_pkg::A_FAULT,
      dor_pkg::A_STATUS, dor_pkg::A_IRQ_STAT, dor_pkg::A_IRQ_CLR,
      dor_pkg::A_IRQ_EN: is_mapped = 1'b1;
      default:           is_mapped = 1'b0;
    endcase
  endfunction

  // pins from outside the clock domain
  assign pin_raw = {enc_dir_pin, enc_step_pin, stop_pin};
  for (genvar g = 0; g < 3; g++) begin : g_sync
    dor_sync u_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .d       (pin_raw[g]),
      .q       (pin_q[g])
    );
  end
  assign stop_sync  = pin_q[0];
  assign enc_step_s = pin_q[1];
  assign enc_dir_s  = pin_q[2];

  // apb slave, zero wait states, read data captured in the setup cycle
  assign setup   = psel & ~penable;
  assign pready  = 1'b1;
  assign wr      = psel & penable & pwrite;
  assign pslverr = psel & penable & ~is_mapped(paddr);

  always_comb begin
    case (paddr)
      dor_pkg::A_OUT_CFG:  apb_rd = {{(32-NO*FW){1'b0}}, out_cfg};
      dor_pkg::A_OUT_STAT: apb_rd = {28'h000_0000, out_pin};
      dor_pkg::A_DEBOUNCE: apb_rd = {24'h00_0000, deb_time};
      dor_pkg::A_FEEDBACK: apb_rd = feedback;
      dor_pkg::A_POSITION: apb_rd = position;
      dor_pkg::A_ACCEL:    apb_rd = accel;
      dor_pkg::A_ANALOG:   apb_rd = {24'h00_0000, analog_in}; // [RULE_15]
      dor_pkg::A_FAULT:    apb_rd = {26'h000_0000, fault_reg};
      dor_pkg::A_STATUS:   apb_rd = {26'h000_0000, status_reg};
      dor_pkg::A_IRQ_STAT: apb_rd = {28'h000_0000, irq_stat};
      dor_pkg::A_IRQ_EN:   apb_rd = {28'h000_0000, irq_en};
      default:             apb_rd = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup && !pwrite) begin
      prdata <= apb_rd;
    end
  end

  // sequencer command path
  assign seq_op  = dor_pkg::dor_op_e'(seq_cmd_op);
  // a process, not assigns: the mux must follow the registers it reads
  always_comb begin
    op_a = opd_val(seq_src_a);
    op_b = seq_use_imm ? seq_imm : opd_val(seq_src_b);
  end
  assign seq_set = seq_cmd_valid && (seq_op == dor_pkg::OP_OUTSET);
  assign seq_wr  = seq_cmd_valid && (seq_op != dor_pkg::OP_OUTSET);
  assign apb_set = wr && (paddr == dor_pkg::A_OUT_SET);
  assign set_any = seq_set | apb_set;

  dor_alu u_alu (
    .a  (op_a),
    .b  (op_b),
    .op (seq_op),
    .y  (alu_y)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seq_result       <= 32'h0000_0000;
      seq_result_valid <= 1'b0;
    end else begin
      seq_result_valid <= seq_wr; // [RULE_12]
      if (seq_wr) begin
        seq_result <= alu_y;
      end
    end
  end

  // writable operands: bus write beats a sequencer write in the same cycle;
  // analog, fault, status and output state have no write path [RULE_13]
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      accel <= dor_pkg::ACCEL_RST;
    end else if (wr && paddr == dor_pkg::A_ACCEL) begin
      accel <= pwdata; // [RULE_14]
    end else if (seq_wr && seq_dst == dor_pkg::OPD_ACCEL) begin
      accel <= alu_y; // [RULE_14]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      deb_time <= dor_pkg::DEB_RST;
    end else if (wr && paddr == dor_pkg::A_DEBOUNCE) begin
      deb_time <= pwdata[7:0]; // [RULE_08]
    end else if (seq_wr && seq_dst == dor_pkg::OPD_DEBOUNCE) begin
      // out-of-range results saturate rather than wrap
      deb_time <= (alu_y > {24'h00_0000, dor_pkg::DEB_MAX}) ?
                  dor_pkg::DEB_MAX : alu_y[7:0]; // [RULE_08]
    end
  end

  // encoder count only; homing and stall logic are left to the program
  assign enc_edge  = enc_step_s & ~enc_step_d;
  assign fb_wr_any = (wr && paddr == dor_pkg::A_FEEDBACK) ||
                     (seq_wr && seq_dst == dor_pkg::OPD_FEEDBACK);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enc_step_d <= 1'b0;
      feedback   <= 32'h0000_0000;
    end else begin
      enc_step_d <= enc_step_s;
      if (wr && paddr == dor_pkg::A_FEEDBACK) begin
        feedback <= pwdata; // [RULE_09]
      end else if (seq_wr && seq_dst == dor_pkg::OPD_FEEDBACK) begin
        feedback <= alu_y; // [RULE_09]
      end else if (enc_edge) begin
        // wraps across the signed range [RULE_11]
        feedback <= enc_dir_s ? feedback + 32'h0000_0001 :
                                feedback - 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      position <= 32'h0000_0000;
    end else if (wr && paddr == dor_pkg::A_POSITION) begin
      position <= pwdata; // [RULE_10]
    end else if (seq_wr && seq_dst == dor_pkg::OPD_POSITION) begin
      position <= alu_y; // [RULE_10]
    end else if (pos_step) begin
      position <= pos_dir ? position + 32'h0000_0001 :
                            position - 32'h0000_0001;
    end
  end

  // stop input debounce in millisecond ticks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt <= 32'h0000_0000;
      deb_tick <= 1'b0;
    end else begin
      deb_tick <= (tick_cnt == 32'(DEB_UNIT_CYC - 1));
      if (tick_cnt == 32'(DEB_UNIT_CYC - 1)) begin
        tick_cnt <= 32'h0000_0000;
      end else begin
        tick_cnt <= tick_cnt + 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      deb_cnt    <= 8'h00;
      stop_clean <= 1'b0;
    end else if (stop_sync == stop_clean) begin
      deb_cnt <= 8'h00;
    end else if (deb_cnt >= deb_time) begin
      stop_clean <= stop_sync; // [RULE_08]
      deb_cnt    <= 8'h00;
    end else if (deb_tick) begin
      deb_cnt <= deb_cnt + 8'h01;
    end
  end

  // status and fault snapshots, refreshed every cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_reg  <= '0;
      status_reg <= '0;
    end else begin
      fault_reg <= {stop_clean, sw_fault, hw_fault}; // [RULE_03]
      status_reg[dor_pkg::ST_SLEW]  <= vel_at_target & ~decelerating;
      status_reg[dor_pkg::ST_MOVE]  <= motor_moving;
      status_reg[dor_pkg::ST_DELAY] <= in_delay;
      status_reg[dor_pkg::ST_STOP]  <= stop_clean;
      status_reg[dor_pkg::ST_DIS]   <= drv_disabled;
      status_reg[dor_pkg::ST_SEQ]   <= seq_active;
    end
  end

  // general-purpose levels change only on set commands
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_gp <= '0;
    end else if (apb_set) begin
      out_gp <= apply_set(out_gp, pwdata[2*NO-1:0]); // [RULE_02]
    end else if (seq_set) begin
      out_gp <= apply_set(out_gp, seq_imm[2*NO-1:0]); // [RULE_02]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_cfg <= '0;
    end else if (wr && paddr == dor_pkg::A_OUT_CFG) begin
      out_cfg <= pwdata[NO*FW-1:0]; // [RULE_01]
    end
  end

  for (genvar i = 0; i < NO; i++) begin : g_out
    logic [FW-1:0] fn;
    assign fn = out_cfg[i*FW +: FW];
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        out_pin[i] <= 1'b0;
      end else begin
        case (fn) // [RULE_01] [RULE_16]
          dor_pkg::FN_GP:    out_pin[i] <= out_gp[i]; // [RULE_02]
          dor_pkg::FN_FAULT: out_pin[i] <= |fault_reg; // [RULE_03]
          dor_pkg::FN_SEQ:
            out_pin[i] <= status_reg[dor_pkg::ST_SEQ]; // [RULE_05]
          dor_pkg::FN_MOVE:
            out_pin[i] <= status_reg[dor_pkg::ST_MOVE]; // [RULE_06]
          dor_pkg::FN_SLEW:
            out_pin[i] <= status_reg[dor_pkg::ST_SLEW]; // [RULE_07]
          default:           out_pin[i] <= 1'b0;
        endcase
      end
    end

    a_gp_hold: assert property (@(posedge pclk) disable iff (!presetn)
      (fn == dor_pkg::FN_GP && !set_any ##1 fn == dor_pkg::FN_GP)
      |=> $stable(out_pin[i])) // [RULE_02]
      else $error("gp output changed without a set command");
    a_fault_out: assert property (@(posedge pclk) disable iff (!presetn)
      (hw_fault != 4'h0 ##1 fn == dor_pkg::FN_FAULT) |=> out_pin[i]) // [RULE_03]
      else $error("fault output not active after hardware fault");
    a_seq_out: assert property (@(posedge pclk) disable iff (!presetn)
      (seq_active ##1 fn == dor_pkg::FN_SEQ) |=> out_pin[i]) // [RULE_05]
      else $error("sequence output not active while running");
    a_move_idle: assert property (@(posedge pclk) disable iff (!presetn)
      (!motor_moving ##1 fn == dor_pkg::FN_MOVE) |=> !out_pin[i]) // [RULE_06]
      else $error("moving output active while stopped");
    a_slew_decel: assert property (@(posedge pclk) disable iff (!presetn)
      (decelerating ##1 fn == dor_pkg::FN_SLEW) |=> !out_pin[i]) // [RULE_07]
      else $error("slew output active during deceleration");
  end

  // interrupts: sticky status, set wins over a clear in the same cycle
  assign irq_evt[dor_pkg::IRQ_FAULT]      = (|fault_reg) & ~fault_d;
  assign irq_evt[dor_pkg::IRQ_SEQ_DONE]   = seq_d & ~status_reg[dor_pkg::ST_SEQ];
  assign irq_evt[dor_pkg::IRQ_MOVE_START] = status_reg[dor_pkg::ST_MOVE] & ~move_d;
  assign irq_evt[dor_pkg::IRQ_MOVE_DONE]  = move_d & ~status_reg[dor_pkg::ST_MOVE];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_d  <= 1'b0;
      seq_d    <= 1'b0;
      move_d   <= 1'b0;
      irq_stat <= '0;
      irq_en   <= '0;
    end else begin
      fault_d <= |fault_reg;
      seq_d   <= status_reg[dor_pkg::ST_SEQ];
      move_d  <= status_reg[dor_pkg::ST_MOVE];
      if (wr && paddr == dor_pkg::A_IRQ_CLR) begin
        irq_stat <= (irq_stat & ~pwdata[dor_pkg::IRQ_W-1:0]) | irq_evt;
      end else begin
        irq_stat <= irq_stat | irq_evt;
      end
      if (wr && paddr == dor_pkg::A_IRQ_EN) begin
        irq_en <= pwdata[dor_pkg::IRQ_W-1:0];
      end
    end
  end
  assign irq = |(irq_stat & irq_en);

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_fb_hold: assert property (!fb_wr_any && !enc_edge |=> $stable(feedback)) // [RULE_09]
    else $error("feedback changed without load or encoder edge");
  a_pos_load: assert property (seq_wr && seq_dst == dor_pkg::OPD_POSITION &&
    !wr |=> position == $past(alu_y)) // [RULE_10]
    else $error("position not loaded by command");
  a_deb_sat: assert property (seq_wr && seq_dst == dor_pkg::OPD_DEBOUNCE &&
    !wr && alu_y > 32'h0000_00FF |=> deb_time == dor_pkg::DEB_MAX) // [RULE_08]
    else $error("debounce time did not saturate");
  a_one_result: assert property (seq_wr |=> seq_result_valid &&
    seq_result == $past(alu_y)) // [RULE_12]
    else $error("command result missing");
  a_no_result: assert property (!seq_wr |=> !seq_result_valid) // [RULE_12]
    else $error("result pulse without a command");
  a_ro_accel: assert property (seq_wr && seq_dst != dor_pkg::OPD_ACCEL &&
    !wr |=> $stable(accel)) // [RULE_13]
    else $error("accel changed by a command to another operand");
  a_accel_back: assert property (wr && paddr == dor_pkg::A_ACCEL
    |=> accel == $past(pwdata)) // [RULE_14]
    else $error("accel does not read back last rate");
  a_analog_read: assert property (setup && !pwrite && paddr == dor_pkg::A_ANALOG
    |=> prdata == {24'h00_0000, $past(analog_in)}) // [RULE_15]
    else $error("analog read not sampled at access");

  c_seq_load: cover property (seq_wr && seq_dst == dor_pkg::OPD_FEEDBACK);
  c_out_set:  cover property (seq_set ##1 set_any);
  c_irq:      cover property (!irq ##1 irq);
  c_stop:     cover property (!stop_clean ##1 stop_clean);
endmodule
`default_nettype wire

// >>> tb/dor_plc_model.sv
`timescale 1ns/1ps
`default_nettype none
module dor_plc_model (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic ok_pin,
  output var  logic ok_lost
);
  logic seen_ok;
  // once raised, any drop of the ok output means a dead drive
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seen_ok <= 1'b0;
      ok_lost <= 1'b0;
    end else begin
      seen_ok <= seen_ok | ok_pin;
      ok_lost <= ok_lost | (seen_ok & ~ok_pin);
    end
  end
endmodule
`default_nettype wire

// >>> tb/dor_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module dor_top_tb;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic        seq_active, motor_moving, vel_at_target, decelerating;
  logic        in_delay, drv_disabled, sw_fault, pos_step, pos_dir, err, vld;
  logic        stop_pin, enc_step_pin, enc_dir_pin, seq_cmd_valid;
  logic        seq_use_imm, seq_result_valid, stop_clean, ok_lost;
  logic [7:0]  paddr, analog_in;
  logic [31:0] pwdata, prdata, rd, seq_result, seq_imm;
  logic [3:0]  hw_fault, seq_dst, seq_src_a, seq_src_b, out_pin;
  logic [2:0]  seq_cmd_op;
  int          err_total, tests_run;

  dor_top #(.DEB_UNIT_CYC(4)) dor_top_inst (.pclk, .presetn, .paddr,
    .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .irq,
    .seq_active, .motor_moving, .vel_at_target, .decelerating, .in_delay,
    .drv_disabled, .sw_fault, .hw_fault, .pos_step, .pos_dir, .analog_in,
    .stop_pin, .enc_step_pin, .enc_dir_pin, .seq_cmd_valid, .seq_cmd_op,
    .seq_dst, .seq_src_a, .seq_src_b, .seq_use_imm, .seq_imm, .seq_result,
    .seq_result_valid, .stop_clean, .out_pin);
  dor_plc_model dor_plc_model_inst (.pclk, .presetn, .ok_pin(out_pin[0]),
    .ok_lost);

  always #20 pclk = ~pclk;

  task automatic test_done;
    if (err_total == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %0t seen %h exp %h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // held until pready is seen high at an edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic seq(input logic [2:0] op, input logic [3:0] dst,
                     input logic [3:0] src, input logic [31:0] imm);
    seq_cmd_valid <= 1'b1;
    seq_cmd_op <= op;
    seq_dst <= dst;
    seq_src_a <= src;
    seq_imm <= imm;
    @(posedge pclk);
    seq_cmd_valid <= 1'b0;
    // result pulse stands for the one cycle after the command edge
    @(negedge pclk);
    vld = seq_result_valid;
    tick(2);
  endtask

  initial begin
    {pclk, presetn, psel, penable, pwrite, sw_fault, seq_active} = '0;
    {motor_moving, vel_at_target, decelerating, in_delay} = '0;
    {drv_disabled, pos_step, pos_dir, stop_pin, seq_cmd_valid} = '0;
    {enc_step_pin, enc_dir_pin, paddr, pwdata, hw_fault, seq_imm} = '0;
    {seq_dst, seq_src_a, seq_src_b, seq_cmd_op} = '0;
    seq_use_imm = 1'b1;
    analog_in = 8'hAB;
    err_total = 0;
    tests_run = 0;
    tick(6);
    presetn <= 1'b1;
    tick(1);
    apb(0, dor_pkg::A_OUT_CFG, 0); chk(rd, 0);
    apb(1, dor_pkg::A_OUT_SET, 32'h0000_0086); tick(2);
    chk({28'h0, out_pin}, 32'h0000_0009);
    seq(3'h6, 4'h0, 4'h0, 32'h0000_0048);
    chk({31'h0, vld}, 0);
    chk({28'h0, out_pin}, 32'h0000_0003);
    chk({31'h0, ok_lost}, 0);
    apb(1, dor_pkg::A_OUT_SET, 32'h0000_0001); tick(2);
    chk({31'h0, ok_lost}, 1);
    apb(1, dor_pkg::A_OUT_CFG, 32'h0000_08D1);
    apb(0, dor_pkg::A_OUT_CFG, 0); chk(rd, 32'h0000_08D1);
    apb(1, dor_pkg::A_IRQ_EN, 32'h0000_000F);
    {sw_fault, seq_active, motor_moving, vel_at_target} <= 4'hF; tick(3);
    chk({28'h0, out_pin}, 32'h0000_000F);
    chk({31'h0, irq}, 1);
    decelerating <= 1'b1; tick(3);
    chk({28'h0, out_pin}, 32'h0000_0007);
    {sw_fault, seq_active, motor_moving, vel_at_target} <= 4'h0; tick(3);
    chk({28'h0, out_pin}, 0);
    apb(0, dor_pkg::A_IRQ_STAT, 0); chk(rd, 32'h0000_000F);
    apb(1, dor_pkg::A_IRQ_CLR, 32'h0000_000F); chk({31'h0, irq}, 0);
    apb(1, dor_pkg::A_IRQ_EN, 0);
    hw_fault <= 4'h4; tick(3);
    chk({28'h0, out_pin}, 32'h0000_0001);
    chk({31'h0, irq}, 0);
    {hw_fault, in_delay, drv_disabled} <= 6'h03; tick(3);
    apb(0, dor_pkg::A_STATUS, 0); chk(rd, 32'h0000_0014);
    stop_pin <= 1'b1; tick(12);
    chk({31'h0, stop_clean}, 1);
    chk({28'h0, out_pin}, 32'h0000_0001);
    apb(1, dor_pkg::A_DEBOUNCE, 32'h0000_01FF);
    apb(0, dor_pkg::A_DEBOUNCE, 0); chk(rd, 32'h0000_00FF);
    seq(3'h1, 4'h7, 4'h7, 1);
    apb(0, dor_pkg::A_DEBOUNCE, 0); chk(rd, 32'h0000_00FF);
    apb(1, dor_pkg::A_FEEDBACK, 32'h8000_0000);
    seq(3'h2, 4'h3, 4'h3, 1);
    apb(0, dor_pkg::A_FEEDBACK, 0); chk(rd, 32'h7FFF_FFFF);
    {enc_dir_pin, enc_step_pin} <= 2'h3; tick(8);
    apb(0, dor_pkg::A_FEEDBACK, 0); chk(rd, 32'h8000_0000);
    seq(3'h0, 4'h5, 4'h0, 32'hFFFF_FFFF);
    {pos_dir, pos_step} <= 2'h3; tick(1);
    pos_step <= 1'b0; tick(2);
    apb(0, dor_pkg::A_POSITION, 0); chk(rd, 0);
    seq(3'h0, 4'h1, 4'h0, 5);
    seq(3'h0, 4'h2, 4'h0, 32'h0000_003F);
    apb(0, dor_pkg::A_ANALOG, 0); chk(rd, 32'h0000_00AB);
    apb(0, dor_pkg::A_FAULT, 0); chk(rd, 32'h0000_0020);
    seq(3'h1, 4'h0, 4'h1, 0); chk(seq_result, 32'h0000_00AB);
    chk({31'h0, vld}, 1);
    apb(0, dor_pkg::A_ACCEL, 0); chk(rd, 32'h0000_00AB);
    apb(1, dor_pkg::A_ACCEL, 32'h003F_FFFC);
    apb(0, dor_pkg::A_ACCEL, 0); chk(rd, 32'h003F_FFFC);
    seq(3'h3, 4'h0, 4'h0, 2);
    chk(seq_result, 32'h007F_FFF8);
    seq(3'h5, 4'h0, 4'h0, 7);
    chk(seq_result, 32'h007F_FFFF);
    seq(3'h4, 4'h0, 4'h0, 32'h0000_00F0);
    chk(seq_result, 32'h0000_00F0);
    apb(0, 8'h40, 0); chk({31'h0, err}, 1);
    test_done;
  end

  initial begin
    tick(3000);
    err_total++;
    test_done;
  end
endmodule
`default_nettype wire
